// ### src/ucs_side_pins.sv
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RQ1] Line driver enable rises one bit period before the start bit.
// [RQ2] Line driver enable drops when the stop bit begins.
// [RQ3] Line driver enable is low whenever no character is being sent.
// [RQ4] Suspend power gate output is high during USB suspend.
// [RQ5] Power gate goes low after enumeration, high throughout suspend.
// [RQ6] Suspend indicator is high while active, low while suspended.
// [RQ7] Suspend indicator is low for the whole suspend.
// [RQ8] External bus-powered logic powers down from gate or indicator.
// [RQ9] Every side pin may be a transmit, receive or combined LED.
// [RQ10] LED pin floats when idle and drives low on activity.
// [RQ11] LED activity is stretched by a one-shot to stay visible.
// [RQ12] Combined LED shows activity in either direction.
// [RQ13] A side pin may output a free-running 12 MHz clock.
// [RQ14] Reset: pin two is line driver enable, pin three power gate.
// [RQ15] Serial bit rate never exceeds 3 Mbaud.
// [RQ16] Flow control uses request-to-send out and clear-to-send in.
// [RQ17] Ring indicator low during suspend requests remote wakeup.
// [RQ18] Wakeup request lasts about 20 ms.
// [RQ19] External logic may OR line enable with receiver to mask echo.
// [RQ20] LED stretch length is fixed; each event retriggers it.
module ucs_side_pins
    import ucs_pkg::*;
#(
    parameter int unsigned LED_STRETCH = LED_STRETCH_CYC,
    parameter int unsigned WAKE_HOLD   = WAKE_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // AHB-Lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    // USB engine and UART core, same clock
    input  wire logic                 usb_suspend_i,
    input  wire logic                 usb_configured_i,
    input  wire logic                 tx_req_i,
    output logic                      tx_go_o,
    input  wire logic                 tx_stop_i,
    input  wire logic                 tx_activity_i,
    input  wire logic                 rx_activity_i,
    input  wire logic                 rx_space_i,
    output logic [15:0]               baud_div_o,
    output logic                      remote_wake_o,
    // Pins
    input  wire logic                 cts_n_i,
    input  wire logic                 ring_indicator_n_i,
    output logic                      rts_n_o,
    output logic [SIDE_PINS-1:0]      configurable_side_pins_o,
    output logic [SIDE_PINS-1:0]      configurable_side_pins_oe_n_o
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Drive value and active-low enable for one pin function
    function automatic logic [1:0] pin_drive(input ucs_pin_fn_t fn,
                                             input logic [6:0]  s);
        logic [1:0] r;
        r = 2'b11;
        case (fn)
            FN_TX_LED:   r = s[0] ? 2'b00 : 2'b11; // RQ9 RQ10
            FN_RX_LED:   r = s[1] ? 2'b00 : 2'b11; // RQ10
            FN_TXRX_LED: r = s[2] ? 2'b00 : 2'b11; // RQ12
            FN_LINE_DRV: r = {s[3], 1'b0};
            FN_PWR_GATE: r = {s[4], 1'b0};
            FN_SUSP_IND: r = {s[5], 1'b0};
            FN_CLK12:    r = {s[6], 1'b0}; // RQ13
            default:     r = 2'b11;
        endcase
        return r;
    endfunction

    // ---------------- Register bus ----------------
    logic [14:0]    cfg_ff;
    logic [15:0]    baud_div_ff;
    logic           dp_wr_ff;
    logic [7:0]     dp_addr_ff;
    logic [31:0]    hrdata_ff;
    logic [31:0]    rd_data;
    logic [31:0]    status;
    logic           bus_acc;

    assign bus_acc     = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_ff;
    assign baud_div_o  = baud_div_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dp_wr_ff   <= 1'b0;
            dp_addr_ff <= 8'h00;
        end else begin
            dp_wr_ff   <= bus_acc && hwrite_i;
            dp_addr_ff <= haddr_i[7:0];
        end
    end

    always_comb begin
        if (haddr_i[7:0] == REG_CFG) begin
            rd_data = {17'h0, cfg_ff};
        end else if (haddr_i[7:0] == REG_BAUD) begin
            rd_data = {16'h0, baud_div_ff};
        end else if (haddr_i[7:0] == REG_STATUS) begin
            rd_data = status;
        end else begin
            rd_data = 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_ff <= 32'h0;
        end else if (bus_acc && !hwrite_i) begin
            hrdata_ff <= rd_data;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_ff <= CFG_RST; // RQ14
        end else if (dp_wr_ff && dp_addr_ff == REG_CFG) begin
            cfg_ff <= hwdata_i[14:0];
        end
    end

    // Too small a divisor is clamped, so the line never outruns 3 Mbaud
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            baud_div_ff <= BAUD_DIV_RST;
        end else if (dp_wr_ff && dp_addr_ff == REG_BAUD) begin
            baud_div_ff <= (hwdata_i[15:0] < BAUD_MIN_DIV) ? BAUD_MIN_DIV
                                                            : hwdata_i[15:0]; // RQ15
        end
    end

    // ---------------- Pin synchronisers ----------------
    logic [1:0] cts_sync_ff;
    logic [1:0] ri_sync_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cts_sync_ff <= 2'b11;
            ri_sync_ff  <= 2'b11;
        end else begin
            cts_sync_ff <= {cts_sync_ff[0], cts_n_i};
            ri_sync_ff  <= {ri_sync_ff[0], ring_indicator_n_i};
        end
    end

    // ---------------- Flow control ----------------
    logic rts_n_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rts_n_ff <= 1'b1;
        end else begin
            rts_n_ff <= !rx_space_i; // RQ16
        end
    end

    assign rts_n_o = rts_n_ff;

    // ---------------- Line driver enable ----------------
    ucs_drv_state_t drv_state_ff;
    ucs_drv_state_t nxt_drv_state;
    logic           line_driver_enable_ff;
    logic [15:0]    lead_cyc_ff;
    ucs_tick_if     tk ();

    ucs_bit_timer u_bit_timer (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .tk     (tk)
    );

    assign tk.div     = baud_div_ff;
    assign tk.restart = (drv_state_ff == DRV_IDLE) && tx_req_i && !cts_sync_ff[1]; // RQ16
    assign tx_go_o    = (drv_state_ff == DRV_LEAD) && tk.tick; // RQ1

    always_comb begin
        nxt_drv_state = drv_state_ff;
        case (drv_state_ff)
            DRV_IDLE:  if (tk.restart) nxt_drv_state = DRV_LEAD;
            DRV_LEAD:  if (tk.tick) nxt_drv_state = DRV_SHIFT;
            DRV_SHIFT: if (tx_stop_i) nxt_drv_state = DRV_IDLE; // RQ2
            default:   nxt_drv_state = DRV_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drv_state_ff          <= DRV_IDLE;
            line_driver_enable_ff <= 1'b0;
        end else begin
            drv_state_ff          <= nxt_drv_state;
            line_driver_enable_ff <= (nxt_drv_state != DRV_IDLE); // RQ3
        end
    end

    // Lead length counter, read only by checks below
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lead_cyc_ff <= 16'h0;
        end else if (drv_state_ff == DRV_LEAD) begin
            lead_cyc_ff <= lead_cyc_ff + 16'h1;
        end else begin
            lead_cyc_ff <= 16'h0;
        end
    end

    // ---------------- Suspend outputs ----------------
    logic suspend_power_gate_n_ff;
    logic susp_ind_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            suspend_power_gate_n_ff <= 1'b1;
            susp_ind_ff             <= 1'b0;
        end else begin
            suspend_power_gate_n_ff <= usb_suspend_i || !usb_configured_i; // RQ4 RQ5
            susp_ind_ff             <= !usb_suspend_i; // RQ6 RQ7
        end
    end

    // ---------------- Remote wakeup ----------------
    logic        wake_ff;
    logic [31:0] wake_cnt_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_ff     <= 1'b0;
            wake_cnt_ff <= 32'h0;
        end else if (!usb_suspend_i) begin
            wake_ff     <= 1'b0;
            wake_cnt_ff <= 32'h0;
        end else if (!wake_ff && !ri_sync_ff[1]) begin
            wake_ff     <= 1'b1; // RQ17
            wake_cnt_ff <= WAKE_HOLD[31:0];
        end else if (wake_ff) begin
            wake_ff     <= (wake_cnt_ff > 32'h1); // RQ18
            wake_cnt_ff <= wake_cnt_ff - 32'h1;
        end
    end

    assign remote_wake_o = wake_ff;

    // ---------------- Activity LEDs ----------------
    ucs_act_if tx_act ();
    ucs_act_if rx_act ();
    ucs_act_if all_act ();

    assign tx_act.evt  = tx_activity_i;
    assign rx_act.evt  = rx_activity_i;
    assign all_act.evt = tx_activity_i || rx_activity_i; // RQ12

    ucs_one_shot #(.STRETCH_CYC(LED_STRETCH)) u_tx_shot (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .act    (tx_act)
    );

    ucs_one_shot #(.STRETCH_CYC(LED_STRETCH)) u_rx_shot (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .act    (rx_act)
    );

    ucs_one_shot #(.STRETCH_CYC(LED_STRETCH)) u_all_shot (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .act    (all_act)
    );

    // ---------------- 12 MHz clock output ----------------
    // Phase accumulator: average exact, edges jitter by one 20 ns cycle
    logic [7:0] nco_ff;
    logic       clk12_ff;
    logic [7:0] nco_sum;

    assign nco_sum = nco_ff + NCO_STEP;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nco_ff   <= NCO_RST; // First toggle at once, no long first phase
            clk12_ff <= 1'b0;
        end else if (nco_sum >= NCO_MOD) begin
            nco_ff   <= nco_sum - NCO_MOD;
            clk12_ff <= !clk12_ff; // RQ13
        end else begin
            nco_ff   <= nco_sum;
        end
    end

    // ---------------- Pin mux ----------------
    logic [6:0]           pin_src;
    logic [SIDE_PINS-1:0] nxt_pin;
    logic [SIDE_PINS-1:0] nxt_pin_oe_n;
    logic [SIDE_PINS-1:0] pin_ff;
    logic [SIDE_PINS-1:0] pin_oe_n_ff;

    assign pin_src = {clk12_ff, susp_ind_ff, suspend_power_gate_n_ff,
                      line_driver_enable_ff, all_act.lit, rx_act.lit, tx_act.lit};

    always_comb begin
        for (int i = 0; i < SIDE_PINS; i++) begin
            {nxt_pin[i], nxt_pin_oe_n[i]} =
                pin_drive(ucs_pin_fn_t'(cfg_ff[i*FN_W +: FN_W]), pin_src); // RQ9
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_ff      <= {SIDE_PINS{1'b1}};
            pin_oe_n_ff <= {SIDE_PINS{1'b1}};
        end else begin
            pin_ff      <= nxt_pin;
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

    assign configurable_side_pins_o      = pin_ff;
    assign configurable_side_pins_oe_n_o = pin_oe_n_ff;

    always_comb begin
        status          = 32'h0;
        status[ST_SUSP] = usb_suspend_i;
        status[ST_CONF] = usb_configured_i;
        status[ST_DRV]  = line_driver_enable_ff;
        status[ST_WAKE] = wake_ff;
        status[ST_CTS]  = !cts_sync_ff[1];
        status[ST_LED +: 3] = {all_act.lit, rx_act.lit, tx_act.lit};
    end

    // ---------------- Checks ----------------
    sequence s_lead_start;
        drv_state_ff == DRV_IDLE && tk.restart;
    endsequence

    sequence s_lead_held;
        line_driver_enable_ff && drv_state_ff == DRV_LEAD;
    endsequence

    a_drv_lead: assert property ( // RQ1
        tx_go_o |-> line_driver_enable_ff && lead_cyc_ff == baud_div_ff - 16'h1)
        else $error("line driver lead is not one bit period");

    a_drv_rise: assert property (s_lead_start |=> s_lead_held) // RQ1
        else $error("line driver did not rise with the lead");

    a_drv_release: assert property ( // RQ2
        drv_state_ff == DRV_SHIFT && tx_stop_i |=> !line_driver_enable_ff)
        else $error("line driver not released at stop bit");

    a_drv_idle: assert property ( // RQ3
        drv_state_ff == DRV_IDLE |-> !line_driver_enable_ff)
        else $error("line driver active while idle");

    a_gate_susp: assert property ( // RQ4
        usb_suspend_i |=> suspend_power_gate_n_ff && !susp_ind_ff)
        else $error("power gate or indicator wrong in suspend");

    a_gate_enum: assert property ( // RQ5
        usb_configured_i && !usb_suspend_i |=> !suspend_power_gate_n_ff && susp_ind_ff)
        else $error("power gate or indicator wrong when active");

    a_baud_floor: assert property (baud_div_ff >= BAUD_MIN_DIV) // RQ15
        else $error("bit rate above 3 Mbaud");

    a_wake_req: assert property ( // RQ17
        usb_suspend_i && !ri_sync_ff[1] && !wake_ff |=> wake_ff)
        else $error("ring indicator did not request wakeup");

    a_clk12_run: assert property ( // RQ13
        $stable(clk12_ff) ##1 $stable(clk12_ff) |=> $changed(clk12_ff))
        else $error("clock output stalled");

    a_cts_hold: assert property ( // RQ16
        cts_sync_ff[1] && drv_state_ff == DRV_IDLE |=> drv_state_ff == DRV_IDLE)
        else $error("transmit started without clear to send");

endmodule

`default_nettype wire

// ### common/ucs_pkg.sv
package ucs_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned BAUD_MAX        = 3_000_000;
    localparam logic [15:0] BAUD_MIN_DIV    = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
    localparam int unsigned BAUD_RST_RATE   = 115_200;
    localparam logic [15:0] BAUD_DIV_RST    = 16'(CLK_HZ / BAUD_RST_RATE);
    localparam int unsigned LED_STRETCH_MS  = 50;
    localparam int unsigned LED_STRETCH_CYC = LED_STRETCH_MS * CLK_PER_MS;
    localparam int unsigned WAKE_MS         = 20;
    localparam int unsigned WAKE_CYC        = WAKE_MS * CLK_PER_MS;

    // Clock output synthesis: phase step and modulus in MHz units
    localparam int unsigned CLKOUT_HZ       = 12_000_000;
    localparam logic [7:0]  NCO_STEP        = 8'(2 * CLKOUT_HZ / 1_000_000);
    localparam logic [7:0]  NCO_MOD         = 8'(CLK_HZ / 1_000_000);
    localparam logic [7:0]  NCO_RST         = NCO_MOD - NCO_STEP;

    localparam int unsigned SIDE_PINS       = 5;
    localparam int unsigned FN_W            = 3;

    typedef enum logic [FN_W-1:0] {
        FN_TX_LED,
        FN_RX_LED,
        FN_TXRX_LED,
        FN_LINE_DRV,
        FN_PWR_GATE,
        FN_SUSP_IND,
        FN_CLK12,
        FN_OFF
    } ucs_pin_fn_t;

    typedef enum logic [1:0] {
        DRV_IDLE,
        DRV_LEAD,
        DRV_SHIFT
    } ucs_drv_state_t;

    localparam logic [14:0] CFG_RST = {FN_SUSP_IND, FN_PWR_GATE, FN_LINE_DRV,
                                       FN_RX_LED, FN_TX_LED};

    // Register byte offsets
    localparam logic [7:0] REG_CFG    = 8'h00;
    localparam logic [7:0] REG_BAUD   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // Status bit positions
    localparam int unsigned ST_SUSP = 0;
    localparam int unsigned ST_CONF = 1;
    localparam int unsigned ST_DRV  = 2;
    localparam int unsigned ST_WAKE = 3;
    localparam int unsigned ST_CTS  = 4;
    localparam int unsigned ST_LED  = 5;

endpackage

// ### common/ucs_ifs.sv
`timescale 1ns/1ps
`default_nettype none

interface ucs_act_if;
    logic evt;
    logic lit;
    modport src  (output evt, input lit);
    modport shot (input evt, output lit);
endinterface

interface ucs_tick_if;
    logic        restart;
    logic [15:0] div;
    logic        tick;
    modport user  (output restart, output div, input tick);
    modport timer (input restart, input div, output tick);
endinterface

`default_nettype wire

// ### src/ucs_one_shot.sv
`timescale 1ns/1ps
`default_nettype none

module ucs_one_shot
    import ucs_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = LED_STRETCH_CYC
) (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    ucs_act_if.shot     act
);

    logic [31:0] cnt_ff;

    // Every event reloads, so a busy stream keeps the LED lit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 32'h0;
        end else if (act.evt) begin
            cnt_ff <= STRETCH_CYC[31:0]; // RQ20
        end else if (cnt_ff != 32'h0) begin
            cnt_ff <= cnt_ff - 32'h1;
        end
    end

    assign act.lit = (cnt_ff != 32'h0); // RQ11

    a_shot_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ11
        act.evt |=> act.lit [*8])
        else $error("one-shot did not stretch the event");

    a_shot_end: assert property (@(posedge clk_i) disable iff (!rstn_i) // RQ20
        (cnt_ff == 32'h1 && !act.evt) |=> !act.lit)
        else $error("one-shot did not end after its count");

endmodule

`default_nettype wire

// ### src/ucs_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ucs_bit_timer (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    ucs_tick_if.timer   tk
);

    logic [15:0] cnt_ff;
    logic        run_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 16'h0;
        end else if (tk.restart) begin
            cnt_ff <= tk.div - 16'h1;
        end else if (cnt_ff != 16'h0) begin
            cnt_ff <= cnt_ff - 16'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_ff <= 1'b0;
        end else if (tk.restart) begin
            run_ff <= 1'b1;
        end else if (tk.tick) begin
            run_ff <= 1'b0;
        end
    end

    // Tick lands div cycles after the restart cycle
    assign tk.tick = run_ff && (cnt_ff == 16'h0);

    a_tick_once: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tk.tick && !tk.restart) |=> !tk.tick)
        else $error("bit timer ticked twice");

endmodule

`default_nettype wire

// ### tb/ucs_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Transceiver, LEDs and the UART core's shifter as seen from the side pins
module ucs_far_side (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        send_i,
    input  wire logic        tx_go_i,
    input  wire logic [15:0] baud_i,
    input  wire logic [4:0]  pin_i,
    input  wire logic [4:0]  oe_n_i,
    input  wire logic        rx_line_i,
    output logic             tx_req_o,
    output logic             tx_stop_o,
    output logic             tx_act_o,
    output logic [4:0]       level_o,
    output logic             rxd_o,
    output logic             power_on_o
);
    int cnt;

    // Pull-ups: a released pin reads high
    assign level_o    = pin_i | oe_n_i;
    assign power_on_o = !level_o[3];
    assign rxd_o      = level_o[2] | rx_line_i;

    // Start, eight data bits, then the stop bit begins
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_req_o  <= 1'b0;
            tx_stop_o <= 1'b0;
            tx_act_o  <= 1'b0;
            cnt       <= 0;
        end else begin
            tx_stop_o <= 1'b0;
            tx_act_o  <= 1'b0;
            if (send_i) begin
                tx_req_o <= 1'b1;
            end
            if (tx_go_i) begin
                tx_req_o <= 1'b0;
                cnt      <= 9 * int'(baud_i);
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    tx_stop_o <= 1'b1;
                    tx_act_o  <= 1'b1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/test_ucs_side_pins.sv
`timescale 1ns/1ps
`default_nettype none

module test_ucs_side_pins;
    import ucs_pkg::*;
    localparam int LS = 16;
    localparam int WH = 20;
    logic        clk_i, rstn_i, hwrite, susp, conf, rx_act, tx_b, space, cts_n, ring_n;
    logic        send, hready, hresp, tx_go, tx_req, tx_stop, tx_p, wake, rts_n, p;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] baud;
    logic [4:0]  pins, oe_n;
    logic [3:0]  watch;
    logic        pwr_on, rxd;
    int          failures, checked, m_cfg, m_baud, k, seed;

    ucs_side_pins #(.LED_STRETCH(LS), .WAKE_HOLD(WH)) ucs_side_pins_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .usb_suspend_i(susp), .usb_configured_i(conf), .tx_req_i(tx_req),
        .tx_go_o(tx_go), .tx_stop_i(tx_stop), .tx_activity_i(tx_p | tx_b),
        .rx_activity_i(rx_act), .rx_space_i(space), .baud_div_o(baud),
        .remote_wake_o(wake), .cts_n_i(cts_n), .ring_indicator_n_i(ring_n),
        .rts_n_o(rts_n), .configurable_side_pins_o(pins),
        .configurable_side_pins_oe_n_o(oe_n));

    ucs_far_side ucs_far_side_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .send_i(send), .tx_go_i(tx_go),
        .baud_i(baud), .pin_i(pins), .oe_n_i(oe_n), .rx_line_i(1'b0),
        .tx_req_o(tx_req), .tx_stop_o(tx_stop), .tx_act_o(tx_p), .level_o(),
        .rxd_o(rxd), .power_on_o(pwr_on));

    assign watch = {tx_stop, tx_go, pins[2], wake};

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task close_out;
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Address phase held until hready, then data phase until hready
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task wreg(input logic [7:0] a, input int v);
        ahb(1'b1, a, v);
        if (a == REG_CFG) m_cfg = v & 32'h7FFF;
        if (a == REG_BAUD) m_baud = ((v & 32'hFFFF) < 17) ? 17 : (v & 32'hFFFF);
        ahb(1'b0, a, 32'h0);
        chk("reg readback", (a == REG_CFG) ? m_cfg : m_baud, rd);
    endtask

    task wait_hi(input int w, input int lim);
        k = 0;
        while (watch[w] !== 1'b1 && k < lim) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (watch[w] !== 1'b1) begin
            $display("mismatch wait %0d expected 1 seen %b", w, watch[w]);
            failures++;
        end
    endtask

    initial begin
        #200us;
        failures++;
        close_out();
    end

    initial begin
        seed = 22;
        failures = 0;
        checked = 0;
        m_cfg = 32'h58C8;
        m_baud = 434;
        {hwrite, susp, conf, rx_act, tx_b, space, send, ring_n, cts_n} = 9'h3;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        rstn_i = 1'b0;
        cyc(3);
        rstn_i <= 1'b1;
        ahb(1'b0, REG_CFG, 32'h0);
        chk("cfg reset", m_cfg, rd);
        ahb(1'b0, REG_BAUD, 32'h0);
        chk("baud reset", m_baud, rd);
        ahb(1'b0, 8'h0C, $random(seed));
        chk("unmapped", 32'h0, rd);
        #1;
        chk("pin2 idle", 2'b00, {oe_n[2], pins[2]});
        chk("gate before enum", 1'b1, pins[3]);
        cyc(1);
        conf <= 1'b1;
        cyc(4);
        #1;
        chk("gate enumerated", 1'b0, pins[3]);
        chk("indicator active", 1'b1, pins[4]);
        chk("logic powered", 1'b1, pwr_on);
        cyc(1);
        susp <= 1'b1;
        ring_n <= 1'b0;
        cyc(4);
        #1;
        chk("gate suspend", 1'b1, pins[3]);
        chk("indicator suspend", 1'b0, pins[4]);
        chk("logic off", 1'b0, pwr_on);
        wait_hi(0, 4);
        chk("wake", 1'b1, wake);
        ring_n <= 1'b1;
        k = 0;
        while (wake === 1'b1 && k < 99) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk("wake hold", 1'b1, k >= WH - 3 && k <= WH + 3);
        cyc(1);
        susp <= 1'b0;
        space <= 1'b1;
        wreg(REG_BAUD, 5);
        wreg(REG_BAUD, 17 + ($random(seed) & 15));
        #1;
        chk("rts asserted", 1'b0, rts_n);
        cyc(1);
        space <= 1'b0;
        send <= 1'b1;
        cyc(1);
        send <= 1'b0;
        cyc(30);
        #1;
        chk("rts released", 1'b1, rts_n);
        chk("cts refuses", 1'b0, pins[2]);
        cyc(1);
        cts_n <= 1'b0;
        wait_hi(1, 99);
        wait_hi(2, 999);
        // Pin lags the enable by one edge; start bit follows tx_go by one
        chk("lead", m_baud, k + 2);
        wait_hi(3, 9999);
        chk("enable at stop", 1'b1, pins[2]);
        chk("echo masked", 1'b1, rxd);
        cyc(2);
        #1;
        chk("enable off", 1'b0, pins[2]);
        chk("echo open", 1'b0, rxd);
        chk("tx led lit", 2'b00, {oe_n[0], pins[0]});
        cyc(LS + 3);
        #1;
        chk("tx led float", 1'b1, oe_n[0]);
        cyc(1);
        rx_act <= 1'b1;
        cyc(1);
        rx_act <= 1'b0;
        cyc(LS - 4);
        rx_act <= 1'b1;
        cyc(1);
        rx_act <= 1'b0;
        cyc(LS - 4);
        #1;
        chk("retrigger", 1'b0, oe_n[1]);
        cyc(10);
        #1;
        chk("stretch ends", 1'b1, oe_n[1]);
        for (int c = 0; c < 3; c++) begin
            for (int d = 0; d < 2; d++) begin
                wreg(REG_CFG, (m_cfg & 32'h7FC7) | (c << 3));
                if (d == 1) rx_act <= 1'b1;
                else tx_b <= 1'b1;
                cyc(1);
                rx_act <= 1'b0;
                tx_b <= 1'b0;
                cyc(3);
                #1;
                chk("led select", (c == 2 || c == d) ? 1'b0 : 1'b1, oe_n[1]);
                cyc(LS + 4);
            end
        end
        wreg(REG_CFG, (m_cfg & 32'h7FC7) | 32'h30);
        cyc(4);
        #1;
        k = 0;
        repeat (250) begin
            p = pins[1];
            @(posedge clk_i);
            #1;
            if (pins[1] !== p) k++;
        end
        chk("clock toggles", 1'b1, k >= 118 && k <= 122);
        close_out();
    end
endmodule

`default_nettype wire
